// ==== flash_pkg.sv ====
// Shared constants for the flash program/erase control block
package flash_pkg;
  // Register addresses on the byte-wide register port
  localparam logic [7:0] ADDR_CODE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PROG_SEL = 8'h01;
  localparam logic [7:0] ADDR_ERASE_SEL = 8'h02;
  localparam logic [7:0] ADDR_UNLOCK = 8'h03;
  localparam logic [7:0] ADDR_ARRAY_SEL = 8'h04;
  localparam logic [7:0] ADDR_DL_DEST = 8'h05;
  localparam logic [7:0] ADDR_RAM_EMU = 8'h06;
  localparam logic [7:0] ADDR_MODE_STAT = 8'h07;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_CLEAR = 8'h09;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h0A;

  // Code control/status field positions
  localparam int CCS_REQ_BIT = 0;
  localparam int CCS_ERR_BIT = 4;
  localparam int CCS_ONE_BIT = 7;

  // Interrupt field positions
  localparam int INT_DL_DONE_BIT = 0;
  localparam int INT_ERR_BIT = 1;

  // Reset values, unlock code and boot mode pin code
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_INT = 2'h0;
  localparam logic [7:0] UNLOCK_CODE = 8'hA5;
  localparam logic [2:0] BOOT_MODE_CODE = 3'h4;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int DOWNLOAD_TIME_NS = 2000;
  localparam int DOWNLOAD_CYCLES =
    (DOWNLOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DOWNLOAD_LAST = 8'(DOWNLOAD_CYCLES - 1);

  // Download sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_COPY = 2'b10
  } dl_state_t;
endpackage

// ==== flash_program_erase_control.sv ====
// Flash program/erase control: byte registers, download, error protect
//
// Function
// - Interface registers are byte wide, byte access
// - Power-on reset restores every register value
// - Bit 7 reads one, reserved bits zero
// - Bit 4 error flag sets on fault
// - Error flag blocks further program and erase
// - Bit 0 write starts routine download
// - Boot mode uses dedicated serial pin pair
// - Interrupt, read, sleep, bus grant during program/erase raise error
// - Request bit clears when copy completes
//
// Register map, byte offsets
// 00 code control/status: bit 7 one, bit 4 error, bit 0 request
// 01 program routine select
// 02 erase routine select
// 03 unlock code
// 04 array select
// 05 download destination
// 06 RAM emulation, nonzero means on
// 07 mode status: bit 3 boot mode, bits 2:0 synced pins
// 08 interrupt status, read only
// 09 interrupt clear, write one to clear
// 0A interrupt enable
// Interrupt bit 0 download done, bit 1 error flag set
`timescale 1ns/1ps
module flash_program_erase_control
  import flash_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic pe_active,
  input wire logic cpu_irq_taken,
  input wire logic flash_read,
  input wire logic sleep_exec,
  input wire logic other_master_grant,
  input wire logic [2:0] mode_select_pins,
  output logic boot_mode,
  output logic boot_serial_tx,
  input wire logic boot_serial_rx,
  input wire logic boot_tx_data,
  output logic boot_rx_data,
  output logic download_active,
  output logic download_erase_routine,
  output logic [7:0] download_dest,
  output logic pe_permit,
  output logic error_protect,
  output logic [7:0] array_select,
  output logic ram_emulation_on,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] program_routine_select_reg;
  logic [7:0] erase_routine_select_reg;
  logic [7:0] unlock_code_reg;
  logic [7:0] array_select_reg;
  logic [7:0] download_destination_reg;
  logic [7:0] ram_emulation_reg;
  logic flash_error_flag_reg;
  logic flash_error_flag_next;
  logic dl_req_reg;
  logic dl_req_next;
  dl_state_t state_reg;
  dl_state_t state_next;
  logic [7:0] dl_count_reg;
  logic [7:0] dl_count_next;
  logic [1:0] int_status_reg;
  logic [1:0] int_status_next;
  logic [1:0] int_enable_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [2:0] mode_meta_reg;
  logic [2:0] mode_sync_reg;
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic tx_reg;

  ////////////////////////////////////////////////////////////////////
  // Address decode, byte-only port
  // Read-only and unmapped offsets get no write strobe
  wire wr_code_ctrl = reg_wr && (reg_addr == ADDR_CODE_CTRL);
  wire wr_prog_sel = reg_wr && (reg_addr == ADDR_PROG_SEL);
  wire wr_erase_sel = reg_wr && (reg_addr == ADDR_ERASE_SEL);
  wire wr_unlock = reg_wr && (reg_addr == ADDR_UNLOCK);
  wire wr_array_sel = reg_wr && (reg_addr == ADDR_ARRAY_SEL);
  wire wr_dl_dest = reg_wr && (reg_addr == ADDR_DL_DEST);
  wire wr_ram_emu = reg_wr && (reg_addr == ADDR_RAM_EMU);
  wire wr_int_clear = reg_wr && (reg_addr == ADDR_INT_CLEAR);
  wire wr_int_enable = reg_wr && (reg_addr == ADDR_INT_ENABLE);

  ////////////////////////////////////////////////////////////////////
  // Download request qualification
  // Request is honoured only unlocked, emulation off, no error;
  // otherwise the write is dropped so a stray write cannot swap
  // the array out from under running code.
  wire unlocked = (unlock_code_reg == UNLOCK_CODE);
  wire emu_off = (ram_emulation_reg == RESET_BYTE);
  wire req_written = wr_code_ctrl && reg_wdata[CCS_REQ_BIT];
  wire dl_start = req_written && (state_reg == ST_IDLE) &&
                  unlocked && emu_off && !flash_error_flag_reg;
  wire dl_done = (state_reg == ST_COPY) &&
                 (dl_count_reg == DOWNLOAD_LAST);

  // Fault sources only count while a program/erase is running
  // Sources are same-clock strobes, so no synchroniser here
  wire fault_src = cpu_irq_taken || flash_read || sleep_exec ||
                   other_master_grant;
  wire fault = pe_active && fault_src;

  ////////////////////////////////////////////////////////////////////
  // Download sequencer
  // Count runs 0 to DOWNLOAD_LAST, one cycle per step of the copy
  always_comb begin
    state_next = state_reg;
    dl_count_next = dl_count_reg;
    unique case (state_reg)
      ST_IDLE: begin
        dl_count_next = RESET_BYTE;
        if (dl_start) begin
          state_next = ST_COPY;
        end
      end
      ST_COPY: begin
        dl_count_next = dl_count_reg + 8'h01;
        if (dl_done) begin
          state_next = ST_IDLE;
          dl_count_next = RESET_BYTE;
        end
      end
      // Illegal one-hot codes fall back to idle
      default: begin
        state_next = ST_IDLE;
        dl_count_next = RESET_BYTE;
      end
    endcase
  end

  // Request bit follows the copy; software cannot clear it early
  // Writing zero while copying has no effect
  always_comb begin
    dl_req_next = dl_req_reg;
    if (dl_start) begin
      dl_req_next = 1'b1;
    end else if (dl_done) begin
      dl_req_next = 1'b0;
    end
  end

  // Error flag: set by faults only, no write path, reset clears
  // A stray write must never drop protection mid-operation
  always_comb begin
    flash_error_flag_next = flash_error_flag_reg;
    if (fault) begin
      flash_error_flag_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt status: hardware set wins over software clear
  // Clear first, then merge events; error bit only on first set
  wire [1:0] int_set = {fault && !flash_error_flag_reg, dl_done};
  always_comb begin
    int_status_next = int_status_reg;
    if (wr_int_clear) begin
      int_status_next = int_status_reg & ~reg_wdata[1:0];
    end
    int_status_next = int_status_next | int_set;
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux, data one cycle after the strobe
  // Zero outside a read cycle keeps the port quiet between reads
  wire [7:0] code_ctrl_view;
  assign code_ctrl_view = {1'b1, 2'b00, flash_error_flag_reg,
                           3'b000, dl_req_reg};
  always_comb begin
    rdata_next = RESET_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CODE_CTRL: rdata_next = code_ctrl_view;
        ADDR_PROG_SEL: rdata_next = program_routine_select_reg;
        ADDR_ERASE_SEL: rdata_next = erase_routine_select_reg;
        ADDR_UNLOCK: rdata_next = unlock_code_reg;
        ADDR_ARRAY_SEL: rdata_next = array_select_reg;
        ADDR_DL_DEST: rdata_next = download_destination_reg;
        ADDR_RAM_EMU: rdata_next = ram_emulation_reg;
        ADDR_MODE_STAT: rdata_next = {4'h0, boot_mode, mode_sync_reg};
        ADDR_INT_STATUS: rdata_next = {6'h00, int_status_reg};
        ADDR_INT_ENABLE: rdata_next = {6'h00, int_enable_reg};
        default: rdata_next = RESET_BYTE; // Unmapped reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Software-written registers
  // Whole bytes only; there are no narrower write lanes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      program_routine_select_reg <= RESET_BYTE;
      erase_routine_select_reg <= RESET_BYTE;
      unlock_code_reg <= RESET_BYTE;
      array_select_reg <= RESET_BYTE;
      download_destination_reg <= RESET_BYTE;
      ram_emulation_reg <= RESET_BYTE;
      int_enable_reg <= RESET_INT;
    end else begin
      if (wr_prog_sel) program_routine_select_reg <= reg_wdata;
      if (wr_erase_sel) erase_routine_select_reg <= reg_wdata;
      if (wr_unlock) unlock_code_reg <= reg_wdata;
      if (wr_array_sel) array_select_reg <= reg_wdata;
      if (wr_dl_dest) download_destination_reg <= reg_wdata;
      if (wr_ram_emu) ram_emulation_reg <= reg_wdata;
      if (wr_int_enable) int_enable_reg <= reg_wdata[1:0];
    end
  end

  // Status, sequencer and read data
  // Flag and sequencer reset together so no copy survives reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flash_error_flag_reg <= 1'b0;
      dl_req_reg <= 1'b0;
      state_reg <= ST_IDLE;
      dl_count_reg <= RESET_BYTE;
      int_status_reg <= RESET_INT;
      rdata_reg <= RESET_BYTE;
    end else begin
      flash_error_flag_reg <= flash_error_flag_next;
      dl_req_reg <= dl_req_next;
      state_reg <= state_next;
      dl_count_reg <= dl_count_next;
      int_status_reg <= int_status_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers; second stage alone feeds logic
  // Receive line resets to its idle high, so no false start bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_meta_reg <= 3'h0;
      mode_sync_reg <= 3'h0;
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      mode_meta_reg <= mode_select_pins;
      mode_sync_reg <= mode_meta_reg;
      rx_meta_reg <= boot_serial_rx;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Serial line idles high outside boot mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_reg <= 1'b1;
    end else begin
      tx_reg <= boot_mode ? boot_tx_data : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  // Boot pins
  assign boot_mode = (mode_sync_reg == BOOT_MODE_CODE);
  assign boot_serial_tx = tx_reg;
  assign boot_rx_data = boot_mode ? rx_sync_reg : 1'b1;
  // Register port
  assign reg_rdata = rdata_reg;
  // Copy engine control
  assign download_active = (state_reg == ST_COPY);
  assign download_erase_routine =
    (erase_routine_select_reg != RESET_BYTE);
  assign download_dest = download_destination_reg;
  // Protect state holds until a power-on reset
  assign error_protect = flash_error_flag_reg;
  assign pe_permit = unlocked && !flash_error_flag_reg;
  // Array and emulation control
  assign array_select = array_select_reg;
  assign ram_emulation_on = !emu_off;
  // Level interrupt, high while an enabled bit stands
  assign irq = |(int_status_reg & int_enable_reg);

endmodule

// ==== flash_ctl_properties.sv ====
// Port timing checks of the flash control block
`timescale 1ns/1ps
module flash_ctl_properties
  import flash_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic pe_active,
  input wire logic cpu_irq_taken,
  input wire logic flash_read,
  input wire logic sleep_exec,
  input wire logic other_master_grant,
  input wire logic boot_mode,
  input wire logic boot_serial_tx,
  input wire logic download_active,
  input wire logic pe_permit,
  input wire logic error_protect
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Any fault source counts only while the routine runs
  wire fault = pe_active & (cpu_irq_taken | flash_read | sleep_exec |
    other_master_grant);
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
  a_fixed_bits: assert property (
    $past(reg_rd) && $past(reg_addr) == ADDR_CODE_CTRL
    |-> (reg_rdata & 8'hEE) == 8'h80) else $error("fixed bits wrong");
  a_fault_sets: assert property (
    fault |=> error_protect) else $error("fault missed");
  a_err_sticky: assert property (
    error_protect |=> error_protect) else $error("error flag dropped");
  a_err_blocks: assert property (
    error_protect |-> !pe_permit) else $error("permit in error");
  a_dl_length: assert property (
    $rose(download_active) |-> ##49 download_active ##1 !download_active)
    else $error("download length wrong");
  a_dl_no_err: assert property (
    $rose(download_active) |-> !$past(error_protect))
    else $error("download in error");
  a_tx_idle: assert property (
    !boot_mode && !$past(boot_mode) |-> boot_serial_tx)
    else $error("tx not idle");
endmodule

// ==== pe_host_model.sv ====
// CPU side model raising fault events during a routine
`timescale 1ns/1ps
module pe_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [1:0] src,
  output logic pe_active,
  output logic [3:0] ev
);
  logic [2:0] cnt_reg;
  // Routine runs four cycles so the event lands mid-run
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cnt_reg <= 3'h0;
    else if (start) cnt_reg <= 3'h4;
    else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
  end
  assign pe_active = cnt_reg != 3'h0;
  assign ev = (cnt_reg == 3'h2) ? 4'h1 << src : 4'h0;
endmodule

// ==== testbench.sv ====
// Self-checking bench of the flash control block
`timescale 1ns/1ps
module testbench;
  import flash_pkg::*;
  logic sys_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic go = 1'h0, btx = 1'h1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
  logic [2:0] mode = 3'h0;
  logic [1:0] src = 2'h0;
  logic [3:0] ev;
  logic pe, bm, tx, rx, dla, perm, errp, irq;
  logic dlerase, emuon;
  logic [7:0] dldest, arrsel;
  int err_count = 0, n_checks = 0, cyc = 0;
  pe_host_model host (.sys_clk, .rst, .start(go), .src, .pe_active(pe),
    .ev);
  flash_program_erase_control DUT (.sys_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata(rdata), .pe_active(pe),
    .cpu_irq_taken(ev[0]), .flash_read(ev[1]), .sleep_exec(ev[2]),
    .other_master_grant(ev[3]), .mode_select_pins(mode), .boot_mode(bm),
    .boot_serial_tx(tx), .boot_serial_rx(btx), .boot_tx_data(btx),
    .boot_rx_data(rx), .download_active(dla),
    .download_erase_routine(dlerase), .download_dest(dldest),
    .pe_permit(perm), .error_protect(errp), .array_select(arrsel),
    .ram_emulation_on(emuon), .irq);
  initial forever #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 chk(rdata, e);
  endtask
  task do_reset(input int n);
    @(posedge sys_clk);
    rst <= 1'h1;
    repeat (n) @(posedge sys_clk);
    rst <= 1'h0;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, well above the longest expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    do_reset(4);
    for (int a = 0; a < 12; a++) rd(8'(a), a == 0 ? 8'h80 : 8'h00);
    wr(ADDR_CODE_CTRL, 8'hFE);
    rd(ADDR_CODE_CTRL, 8'h80);
    for (int a = 1; a < 6; a++) begin
      wr(8'(a), 8'(a * 17));
      rd(8'(a), 8'(a * 17));
    end
    chk({7'h0, dlerase}, 8'h01);
    chk(dldest, 8'h55);
    chk(arrsel, 8'h44);
    rd(ADDR_ARRAY_SEL, 8'h44);
    chk({7'h0, perm}, 8'h00);
    // Unlock byte is not the code: request must be refused
    wr(ADDR_CODE_CTRL, 8'h01);
    chk({7'h0, dla}, 8'h00);
    $display("test regs done");
    // Emulation on: request must be refused
    wr(ADDR_RAM_EMU, 8'h01);
    chk({7'h0, emuon}, 8'h01);
    wr(ADDR_UNLOCK, UNLOCK_CODE);
    wr(ADDR_CODE_CTRL, 8'h01);
    chk({7'h0, dla}, 8'h00);
    wr(ADDR_RAM_EMU, 8'h00);
    chk({7'h0, emuon}, 8'h00);
    wr(ADDR_INT_ENABLE, 8'h03);
    wr(ADDR_CODE_CTRL, 8'h01);
    rd(ADDR_CODE_CTRL, 8'h81);
    rd(ADDR_CODE_CTRL, 8'h81);
    repeat (60) if (dla) @(posedge sys_clk) #1;
    rd(ADDR_CODE_CTRL, 8'h80);
    rd(ADDR_INT_STATUS, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(ADDR_INT_CLEAR, 8'h01);
    chk({7'h0, irq}, 8'h00);
    $display("test download done");
    // One fault source per pass, since the flag holds until reset
    for (int k = 0; k < 4; k++) begin
      do_reset(2500);
      wr(ADDR_INT_ENABLE, 8'h02);
      chk(arrsel, 8'h00);
      wr(ADDR_ARRAY_SEL, 8'h01);
      chk(arrsel, 8'h01);
      wr(ADDR_UNLOCK, UNLOCK_CODE);
      chk({7'h0, perm}, 8'h01);
      @(posedge sys_clk);
      src <= 2'(k);
      go <= 1'h1;
      @(posedge sys_clk);
      go <= 1'h0;
      repeat (5) @(posedge sys_clk);
      #1 chk({5'h0, errp, perm, irq}, 8'h05);
      wr(ADDR_CODE_CTRL, 8'hEF);
      rd(ADDR_CODE_CTRL, 8'h90);
      rd(ADDR_INT_STATUS, 8'h02);
    end
    $display("test fault done");
    @(posedge sys_clk);
    mode <= BOOT_MODE_CODE;
    btx <= 1'h0;
    repeat (4) @(posedge sys_clk);
    #1 chk({5'h0, bm, tx, rx}, 8'h04);
    rd(ADDR_MODE_STAT, 8'h0C);
    $display("test boot done");
    stop_test;
  end
endmodule
bind flash_program_erase_control flash_ctl_properties chk_i (.sys_clk,
  .rst, .reg_addr, .reg_rd, .reg_rdata, .pe_active, .cpu_irq_taken,
  .flash_read, .sleep_exec, .other_master_grant, .boot_mode,
  .boot_serial_tx, .download_active, .pe_permit, .error_protect);
